// File: src/mhf_setup.sv
// Purpose: Command engine running multicast setup blocks from host memory
// Assumes: Memory answers each read with mem_rvalid; writes never stall
// Notes: Registers reached over a plain strobe port, read data one cycle on
`timescale 1ns/1ns
module mhf_setup (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Host memory port
    output logic mem_rd,
    output logic mem_wr,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_rvalid,
    // Receive filter
    input wire mhf_pkg::mhf_rx_t rx_in,
    output logic rx_accept,
    output logic rx_decided,
    // Engine events
    output logic block_done_event,
    output logic engine_idle_event,
    output logic engine_not_active_event
);
    import mhf_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] base_q, base_d, cbp_q, cbp_d, rdata_d;
    mhf_cfg_t cfg_q, cfg_d;
    logic start, resume, sw_rst;

    always_comb begin
        base_d = base_q;
        cbp_d = cbp_q;
        cfg_d = cfg_q;
        start = 1'b0;
        resume = 1'b0;
        sw_rst = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                MHF_REG_CTRL: begin
                    start = reg_wdata[MHF_CTRL_START];
                    resume = reg_wdata[MHF_CTRL_RESUME];
                    sw_rst = reg_wdata[MHF_CTRL_SWRST];
                end
                MHF_REG_BASE: base_d = reg_wdata;
                MHF_REG_CBP: cbp_d = reg_wdata;
                MHF_REG_CFG: begin
                    cfg_d.hsa = reg_wdata[MHF_CFG_HSA];
                    cfg_d.all_mc = reg_wdata[MHF_CFG_ALLMC];
                    cfg_d.cna_en = reg_wdata[MHF_CFG_CNAEN];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Command engine
    // ------------------------------------------------------------
    mhf_state_t st_q, st_d;
    mhf_cmd_t cmd_q, cmd_d;
    logic [31:0] link_q, link_d, cb_q, cb_d, la_q, la_d, dw_q, dw_d;
    logic [13:0] rem_q, rem_d, cnt;
    logic [1:0] lane_q, lane_d;
    logic pend_q, pend_d, ok_q, ok_d;
    logic rd_d, wr_d;
    logic [31:0] addr_d, wdata_d;
    logic bdone_d, eidle_d, ena_d;
    logic hclr, bvld, lend, hdone;
    logic [7:0] bdata;
    logic [63:0] table_w;

    always_comb begin
        st_d = st_q;
        cmd_d = cmd_q;
        link_d = link_q;
        cb_d = cb_q;
        la_d = la_q;
        dw_d = dw_q;
        rem_d = rem_q;
        lane_d = lane_q;
        pend_d = pend_q;
        ok_d = ok_q;
        rd_d = 1'b0;
        wr_d = 1'b0;
        addr_d = mem_addr;
        wdata_d = mem_wdata;
        bdone_d = 1'b0;
        eidle_d = 1'b0;
        ena_d = 1'b0;
        hclr = sw_rst; // [RULE_19]
        bvld = 1'b0;
        lend = 1'b0;
        bdata = dw_q[{lane_q, 3'h0} +: 8]; // [RULE_13]
        cnt = mem_rdata[MHF_CNT_W-1:0]; // [RULE_23]
        case (st_q)
            MHF_IDLE: begin
                if (start) begin
                    cb_d = base_q + cbp_q;
                    st_d = MHF_RD_CMD;
                end
            end
            MHF_SUSP: begin
                if (resume) begin
                    st_d = MHF_RD_CMD;
                end
            end
            MHF_RD_CMD, MHF_RD_LINK, MHF_RD_CNT, MHF_RD_LIST: begin
                if (!pend_q) begin
                    rd_d = 1'b1;
                    pend_d = 1'b1;
                    case (st_q)
                        MHF_RD_CMD: addr_d = cb_q;
                        MHF_RD_LINK: addr_d = cb_q + MHF_OFS_LINK;
                        MHF_RD_CNT: addr_d = cb_q + MHF_OFS_CNT;
                        default: addr_d = la_q;
                    endcase
                end else if (mem_rvalid) begin
                    pend_d = 1'b0;
                    case (st_q)
                        MHF_RD_CMD: begin
                            cmd_d = mem_rdata;
                            st_d = MHF_RD_LINK;
                        end
                        MHF_RD_LINK: begin
                            link_d = mem_rdata;
                            st_d = MHF_RD_CNT;
                        end
                        MHF_RD_CNT: begin
                            dw_d = mem_rdata;
                            lane_d = MHF_FIRST_LANE; // [RULE_23]
                            rem_d = cnt - (cnt % MHF_GRP); // [RULE_08]
                            la_d = cb_q + MHF_OFS_LIST;
                            ok_d = (cmd_q.op == MHF_OP_MCSETUP); // [RULE_01]
                            hclr = ok_d; // [RULE_14]
                            st_d = ok_d ? MHF_EMIT : MHF_WR_STAT;
                        end
                        default: begin
                            dw_d = mem_rdata;
                            lane_d = 2'h0;
                            la_d = la_q + MHF_DW_STEP;
                            st_d = MHF_EMIT;
                        end
                    endcase
                end
            end
            MHF_EMIT: begin
                if (rem_q == 14'h0) begin
                    lend = 1'b1; // [RULE_09] [RULE_12]
                    st_d = MHF_WAIT_HASH;
                end else begin
                    bvld = 1'b1; // [RULE_13]
                    rem_d = rem_q - 14'h1;
                    lane_d = lane_q + 2'h1;
                    if (lane_q == 2'h3 && rem_q != 14'h1) begin
                        st_d = MHF_RD_LIST;
                    end
                end
            end
            MHF_WAIT_HASH: begin
                if (hdone) begin
                    st_d = MHF_WR_STAT; // [RULE_17]
                end
            end
            MHF_WR_STAT: begin
                wr_d = 1'b1;
                addr_d = cb_q;
                wdata_d = {cmd_q[31:16], 1'b1, 1'b0, ok_q, 13'h0}; // [RULE_06]
                st_d = MHF_POST;
            end
            MHF_POST: begin
                cb_d = base_q + link_q; // [RULE_11]
                bdone_d = cmd_q.intr; // [RULE_04]
                if (cmd_q.el) begin
                    eidle_d = 1'b1; // [RULE_02]
                    st_d = MHF_IDLE;
                end else if (cmd_q.susp) begin
                    ena_d = cfg_q.cna_en; // [RULE_03]
                    st_d = MHF_SUSP;
                end else begin
                    st_d = MHF_RD_CMD;
                end
            end
            default: st_d = MHF_IDLE;
        endcase
        if (sw_rst) begin
            st_d = MHF_IDLE;
            pend_d = 1'b0;
        end
    end

    always_comb begin
        rdata_d = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                MHF_REG_BASE: rdata_d = base_q;
                MHF_REG_CBP: rdata_d = cbp_q;
                MHF_REG_CFG: begin
                    rdata_d[MHF_CFG_HSA] = cfg_q.hsa;
                    rdata_d[MHF_CFG_ALLMC] = cfg_q.all_mc;
                    rdata_d[MHF_CFG_CNAEN] = cfg_q.cna_en;
                end
                MHF_REG_STAT: rdata_d = {27'h0, ok_q, st_q};
                MHF_REG_HLO: rdata_d = table_w[31:0];
                MHF_REG_HHI: rdata_d = table_w[63:32];
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            base_q <= MHF_BASE_RST;
            cbp_q <= MHF_CBP_RST;
            cfg_q <= MHF_CFG_RST;
            reg_rdata <= 32'h0;
            st_q <= MHF_IDLE;
            cmd_q <= '0;
            link_q <= 32'h0;
            cb_q <= 32'h0;
            la_q <= 32'h0;
            dw_q <= 32'h0;
            rem_q <= 14'h0;
            lane_q <= 2'h0;
            pend_q <= 1'b0;
            ok_q <= 1'b0;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_addr <= 32'h0;
            mem_wdata <= 32'h0;
            block_done_event <= 1'b0;
            engine_idle_event <= 1'b0;
            engine_not_active_event <= 1'b0;
        end else begin
            base_q <= base_d;
            cbp_q <= cbp_d;
            cfg_q <= cfg_d;
            reg_rdata <= rdata_d;
            st_q <= st_d;
            cmd_q <= cmd_d;
            link_q <= link_d;
            cb_q <= cb_d;
            la_q <= la_d;
            dw_q <= dw_d;
            rem_q <= rem_d;
            lane_q <= lane_d;
            pend_q <= pend_d;
            ok_q <= ok_d;
            mem_rd <= rd_d;
            mem_wr <= wr_d;
            mem_addr <= addr_d;
            mem_wdata <= wdata_d;
            block_done_event <= bdone_d;
            engine_idle_event <= eidle_d;
            engine_not_active_event <= ena_d;
        end
    end

    // ------------------------------------------------------------
    // Hash builder and receive filter
    // ------------------------------------------------------------
    mhf_hash_build u_hash (
        .ref_clk(ref_clk),
        .reset(reset),
        .clr(hclr),
        .byte_vld(bvld),
        .byte_in(bdata),
        .list_end(lend),
        .table_q(table_w),
        .done_q(hdone)
    );

    mhf_rx_match u_rx (
        .ref_clk(ref_clk),
        .reset(reset),
        .rx(rx_in),
        .table_in(table_w),
        .cfg(cfg_q),
        .accept_q(rx_accept),
        .decided_q(rx_decided)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset || sw_rst);

    sequence s_list_end;
        st_q == MHF_EMIT && rem_q == 14'h0;
    endsequence
    sequence s_finish;
        st_q == MHF_WAIT_HASH ##1 st_q == MHF_WR_STAT ##1 mem_wr;
    endsequence

    a_list_then_done: assert property (s_list_end |=> s_finish) // [RULE_12]
        else $error("completion did not follow the hash update");
    a_status_done: assert property (mem_wr |-> mem_wdata[15]) // [RULE_06]
        else $error("status write without completion bit");
    a_status_ok: assert property (mem_wr
        |-> mem_wdata[13] == (cmd_q.op == MHF_OP_MCSETUP)) // [RULE_07]
        else $error("no-error bit disagrees with opcode");
    a_done_event: assert property (st_q == MHF_POST
        |=> block_done_event == cmd_q.intr) // [RULE_04]
        else $error("block-done event does not follow its flag");
    a_idle_on_el: assert property (st_q == MHF_POST && cmd_q.el
        |=> st_q == MHF_IDLE && engine_idle_event) // [RULE_02]
        else $error("end of list did not idle the engine");
    a_suspend_on_s: assert property (st_q == MHF_POST && !cmd_q.el &&
        cmd_q.susp |=> st_q == MHF_SUSP &&
        engine_not_active_event == cfg_q.cna_en) // [RULE_03]
        else $error("suspend flag not honoured");
    a_next_link: assert property (st_q == MHF_POST
        |=> cb_q == $past(base_q) + $past(link_q)) // [RULE_11]
        else $error("next block address wrong");
    a_count_round: assert property (st_q == MHF_RD_CNT && pend_q &&
        mem_rvalid && cmd_q.op == MHF_OP_MCSETUP |=> (rem_q % MHF_GRP) == 0
        && rem_q <= $past(mem_rdata[13:0])) // [RULE_08]
        else $error("list length not rounded to whole groups");
endmodule : mhf_setup

// File: src/mhf_pkg.sv
// Purpose: Shared constants and types for the multicast hash filter setup
// Assumes: Command blocks are little-endian dwords in host memory
// Notes:
// How it works
// RULE_01 - Opcode 011b in bits 18:16 of dword 0 means multicast setup
// RULE_02 - End-of-list bit 31 sends engine idle and always raises idle event
// RULE_03 - Suspend bit 30 suspends engine; not-active event only if enabled
// RULE_04 - Interrupt bit 29 raises block-done event; otherwise no event
// RULE_05 - Host writes zeros into reserved command bits 28:19
// RULE_06 - Host clears completion bit 15; device sets it when finished
// RULE_07 - Completion with no-error bit 13 clear means an error occurred
// RULE_08 - 14-bit byte count rounds down to a multiple of 6
// RULE_09 - Zero count leaves hash table fully cleared
// RULE_10 - Host puts multicast bit set in every listed address
// RULE_11 - Next block address is engine base plus 32-bit link
// RULE_12 - Latch count, stream list, wait for hash update, then complete
// RULE_13 - List bytes travel from memory to the hash builder
// RULE_14 - Hash builder clears table, then takes bytes in groups of 6
// RULE_15 - Each full group sets table bit at CRC bits 7:2
// RULE_16 - A trailing partial group leaves the table unchanged
// RULE_17 - Hash builder tells engine when update is finished
// RULE_18 - Hash accept needs multicast bit set and a set table bit
// RULE_19 - Software reset clears the whole hash table; code skips the clear in the cycle a non-setup block's count dword arrives
// RULE_20 - Hashed station address bit 6 applies hash to unicast too
// RULE_21 - Accept-all-multicast bit 3 takes every multicast frame
// RULE_22 - Hash CRC is Ethernet CRC-32 over six bytes in wire order
// RULE_23 - Count in low half of dword 08h, first two bytes above it
package mhf_pkg;
    // ------------------------------------------------------------
    // Command block layout
    // ------------------------------------------------------------
    localparam logic [2:0] MHF_OP_MCSETUP = 3'h3;
    localparam logic [31:0] MHF_OFS_LINK = 32'h4;
    localparam logic [31:0] MHF_OFS_CNT = 32'h8;
    localparam logic [31:0] MHF_OFS_LIST = 32'hc;
    localparam logic [31:0] MHF_DW_STEP = 32'h4;
    localparam int MHF_CNT_W = 14;
    localparam logic [13:0] MHF_GRP = 14'h6;
    localparam logic [1:0] MHF_FIRST_LANE = 2'h2;
    localparam int MHF_HIDX_LSB = 2;
    localparam logic [31:0] MHF_CRC_INIT = 32'hffffffff;
    localparam logic [31:0] MHF_CRC_POLY = 32'hedb88320;

    typedef struct packed {
        logic el;
        logic susp;
        logic intr;
        logic [9:0] rsvd;
        logic [2:0] op;
        logic done;
        logic unused;
        logic ok;
        logic [12:0] st;
    } mhf_cmd_t;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] MHF_REG_CTRL = 8'h00;
    localparam logic [7:0] MHF_REG_BASE = 8'h04;
    localparam logic [7:0] MHF_REG_CBP = 8'h08;
    localparam logic [7:0] MHF_REG_CFG = 8'h0c;
    localparam logic [7:0] MHF_REG_STAT = 8'h10;
    localparam logic [7:0] MHF_REG_HLO = 8'h14;
    localparam logic [7:0] MHF_REG_HHI = 8'h18;
    localparam int MHF_CTRL_START = 0;
    localparam int MHF_CTRL_RESUME = 1;
    localparam int MHF_CTRL_SWRST = 2;
    localparam int MHF_CFG_HSA = 6;
    localparam int MHF_CFG_ALLMC = 3;
    localparam int MHF_CFG_CNAEN = 0;
    localparam logic [31:0] MHF_BASE_RST = 32'h0;
    localparam logic [31:0] MHF_CBP_RST = 32'h0;

    typedef struct packed {
        logic hsa;
        logic all_mc;
        logic cna_en;
    } mhf_cfg_t;

    localparam mhf_cfg_t MHF_CFG_RST = 3'h0;

    typedef struct packed {
        logic vld;
        logic [47:0] da;
    } mhf_rx_t;

    typedef enum logic [3:0] {
        MHF_IDLE = 4'h0,
        MHF_RD_CMD = 4'h1,
        MHF_RD_LINK = 4'h3,
        MHF_RD_CNT = 4'h2,
        MHF_EMIT = 4'h6,
        MHF_RD_LIST = 4'h7,
        MHF_WAIT_HASH = 4'h5,
        MHF_WR_STAT = 4'h4,
        MHF_POST = 4'hc,
        MHF_SUSP = 4'hd
    } mhf_state_t;

    // One byte of reflected CRC-32, least significant bit first
    function automatic logic [31:0] mhf_crc8(logic [31:0] c, logic [7:0] b);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ b[i]) ? ((r >> 1) ^ MHF_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : mhf_crc8
endpackage : mhf_pkg

// File: src/mhf_hash_build.sv
// Purpose: Builds the 64-bit hash table from a stream of list bytes
// Assumes: Bytes arrive one per cycle in wire order
// Notes: Table updates on the edge that takes the sixth byte
`timescale 1ns/1ns
module mhf_hash_build (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Byte stream from the engine
    input wire logic clr,
    input wire logic byte_vld,
    input wire logic [7:0] byte_in,
    input wire logic list_end,
    // Table and completion
    output logic [63:0] table_q,
    output logic done_q
);
    import mhf_pkg::*;

    logic [31:0] crc_q, crc_d, nxt;
    logic [2:0] n_q, n_d;
    logic [63:0] tbl_d;
    logic done_d;

    always_comb begin
        crc_d = crc_q;
        n_d = n_q;
        tbl_d = table_q;
        done_d = 1'b0;
        nxt = mhf_crc8(crc_q, byte_in); // [RULE_22]
        if (clr) begin
            tbl_d = '0; // [RULE_14] [RULE_19]
            crc_d = MHF_CRC_INIT;
            n_d = '0;
        end else if (list_end) begin
            crc_d = MHF_CRC_INIT; // [RULE_16]
            n_d = '0;
            done_d = 1'b1; // [RULE_17]
        end else if (byte_vld) begin
            if (n_q == 3'(MHF_GRP - 14'h1)) begin
                tbl_d[nxt[MHF_HIDX_LSB +: 6]] = 1'b1; // [RULE_15]
                crc_d = MHF_CRC_INIT;
                n_d = '0;
            end else begin
                crc_d = nxt;
                n_d = n_q + 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            crc_q <= MHF_CRC_INIT;
            n_q <= '0;
            table_q <= '0;
            done_q <= 1'b0;
        end else begin
            crc_q <= crc_d;
            n_q <= n_d;
            table_q <= tbl_d;
            done_q <= done_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_group_sets_bit: assert property (byte_vld && !clr && !list_end &&
        n_q == 3'h5 |=> table_q[$past(nxt[7:2])]) // [RULE_15]
        else $error("full group did not set its hash bit");
    a_partial_kept: assert property (list_end && !clr
        |=> table_q == $past(table_q) && done_q) // [RULE_16]
        else $error("partial group changed the table");
endmodule : mhf_hash_build

// File: src/mhf_rx_match.sv
// Purpose: Receive-side address filter using the hash table
// Assumes: Destination address arrives in one cycle, first byte in da[7:0]
// Notes: Decision is registered one cycle after rx.vld
`timescale 1ns/1ns
module mhf_rx_match (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Frame address and filter state
    input wire mhf_pkg::mhf_rx_t rx,
    input wire logic [63:0] table_in,
    input wire mhf_pkg::mhf_cfg_t cfg,
    // Decision
    output logic accept_q,
    output logic decided_q
);
    import mhf_pkg::*;

    logic [31:0] c;
    logic mc, hit, accept_d;

    always_comb begin
        c = MHF_CRC_INIT;
        for (int i = 0; i < 6; i++) begin
            c = mhf_crc8(c, rx.da[8*i +: 8]); // [RULE_22]
        end
        mc = rx.da[0];
        hit = table_in[c[MHF_HIDX_LSB +: 6]];
        accept_d = rx.vld && ((mc && cfg.all_mc) || // [RULE_21]
            (hit && (mc || cfg.hsa))); // [RULE_18] [RULE_20]
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            accept_q <= 1'b0;
            decided_q <= 1'b0;
        end else begin
            accept_q <= accept_d;
            decided_q <= rx.vld;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_unicast_reject: assert property (rx.vld && !rx.da[0] && !cfg.hsa
        |=> !accept_q && decided_q) // [RULE_18]
        else $error("unicast accepted without hashed station mode");
    a_all_multicast: assert property (rx.vld && rx.da[0] && cfg.all_mc
        |=> accept_q) // [RULE_21]
        else $error("multicast frame rejected in accept-all mode");
endmodule : mhf_rx_match

// File: verif/mhf_mem_model.sv
// Purpose: Host memory holding command blocks for the setup engine
// Assumes: Block area sits in the low 256 bytes
// Notes: Read latency set by lat, at least one cycle
`timescale 1ns/1ns
module mhf_mem_model (
    // Clock and latency choice
    input wire logic ref_clk,
    input wire logic [3:0] lat,
    // Memory port
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata,
    output logic mem_rvalid
);
    logic [31:0] mem [0:63];
    logic [31:0] last = 32'h0;
    logic [5:0] ra = 6'h0;
    int cnt = 0;
    initial mem_rvalid = 1'b0;
    initial mem_rdata = 32'h0;
    always @(posedge ref_clk) begin
        mem_rvalid <= 1'b0;
        // Outside an answer the bus shows junk, not the last word
        mem_rdata <= ~last;
        if (mem_wr) mem[mem_addr[7:2]] <= mem_wdata;
        if (mem_rd) begin
            cnt <= lat;
            ra <= mem_addr[7:2];
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            mem_rvalid <= 1'b1;
            mem_rdata <= mem[ra];
            last <= mem[ra];
        end
    end
endmodule : mhf_mem_model

// File: verif/mhf_setup_tb_top.sv
// Purpose: Self-checking bench for the multicast setup engine
// Assumes: Block at offset 40h, base 0
// Notes: Hash expectations from a bench-side CRC
`timescale 1ns/1ns
module mhf_setup_tb_top;
    import mhf_pkg::*;
    logic ref_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_addr, mem_wdata, mem_rdata;
    logic mem_rd, mem_wr, mem_rvalid, rx_accept, rx_decided;
    logic bd_ev, idle_ev, na_ev;
    logic [3:0] lat = 4'h1;
    mhf_rx_t rx_in = '0;
    logic [63:0] tbl = 64'h0;
    logic [47:0] adr [0:3] = '{48'h01005e000001, 48'h554433221101,
        48'h0a0b0c0d0e03, 48'h0};
    logic [31:0] d;
    int n_errors = 0, n_tests = 0, n_bd = 0, n_idle = 0, n_na = 0;

    mhf_setup dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_rvalid(mem_rvalid), .rx_in(rx_in), .rx_accept(rx_accept),
        .rx_decided(rx_decided), .block_done_event(bd_ev),
        .engine_idle_event(idle_ev), .engine_not_active_event(na_ev));
    mhf_mem_model mem_u (.ref_clk(ref_clk), .lat(lat), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        n_bd += int'(bd_ev === 1'b1);
        n_idle += int'(idle_ev === 1'b1);
        n_na += int'(na_ev === 1'b1);
    end

    // Table index: reflected CRC over six bytes, wire order
    function automatic logic [5:0] hidx(logic [47:0] a);
        logic [31:0] c;
        c = 32'hffffffff;
        for (int i = 0; i < 48; i++) begin
            c = (c[0] ^ a[i]) ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
        end
        return c[7:2];
    endfunction : hidx

    task automatic chk(string n, logic [63:0] e, logic [63:0] g);
        n_tests++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask : chk

    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        v = reg_rdata;
    endtask : rd

    task automatic chk_tbl();
        rd(MHF_REG_HLO, d);
        chk("hash_lo", tbl[31:0], d);
        rd(MHF_REG_HHI, d);
        chk("hash_hi", tbl[63:32], d);
    endtask : chk_tbl

    task automatic run_block(logic el, s, i, logic [13:0] cnt, logic [3:0] l);
        logic [7:0] b [0:23];
        logic [31:0] w0;
        for (int k = 0; k < 24; k++) b[k] = adr[k/6][8*(k%6)+:8];
        w0 = {el, s, i, 10'h0, MHF_OP_MCSETUP, 16'h0};
        mem_u.mem[16] = w0;
        mem_u.mem[17] = 32'h80;
        mem_u.mem[18] = {b[1], b[0], 2'h0, cnt};
        for (int k = 0; k < 5; k++)
            mem_u.mem[19+k] = {b[4*k+5], b[4*k+4], b[4*k+3], b[4*k+2]};
        tbl = 64'h0;
        for (int k = 0; k < cnt / 6; k++) tbl[hidx(adr[k])] = 1'b1;
        lat <= l;
        n_bd = 0;
        n_idle = 0;
        n_na = 0;
        wr(MHF_REG_CTRL, 32'h1);
        for (int k = 0; k < 2000 && mem_u.mem[16][15] !== 1'b1; k++)
            @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
        chk("status", {w0[31:16], 16'ha000}, mem_u.mem[16]);
        chk_tbl();
        chk("done_ev", i, n_bd);
        chk("idle_ev", el, n_idle);
        chk("na_ev", s, n_na);
    endtask : run_block

    task automatic rx_chk(logic [47:0] a, logic [2:0] c);
        logic e;
        @(posedge ref_clk);
        rx_in <= {1'b1, a};
        @(posedge ref_clk);
        rx_in <= '0;
        @(negedge ref_clk);
        e = (a[0] && c[1]) || (tbl[hidx(a)] && (a[0] || c[2]));
        chk("rx_accept", e, rx_accept);
        chk("rx_decided", 1, rx_decided);
    endtask : rx_chk

    task automatic wrap_up();
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        chk_tbl();
        rd(8'h3c, d);
        chk("unmapped", 0, d);
        wr(MHF_REG_CBP, 32'h40);
        wr(MHF_REG_CFG, 32'h1);
        run_block(1, 0, 1, 14, 1);
        // Unicast probe that lands on a set table bit
        for (int k = 1; k < 512 && !tbl[hidx(adr[3])]; k++)
            adr[3] = {32'(k), 16'h0};
        foreach (adr[j]) begin
            wr(MHF_REG_CFG, {25'h0, j[1], 2'h0, j[0], 3'h1});
            for (int k = 0; k < 4; k++) rx_chk(adr[k], {j[1:0], 1'b1});
        end
        wr(MHF_REG_CFG, 32'h1);
        wr(MHF_REG_CTRL, 32'h4);
        tbl = 64'h0;
        chk_tbl();
        run_block(1, 0, 0, 18, 3);
        run_block(0, 1, 0, 0, 5);
        rd(MHF_REG_STAT, d);
        chk("state", MHF_SUSP, d[3:0]);
        // Resume into a block with a foreign opcode, not-active event masked
        mem_u.mem[32] = 32'h40010000;
        mem_u.mem[33] = 32'h0;
        mem_u.mem[34] = 32'h6;
        wr(MHF_REG_CFG, 32'h0);
        n_na = 0;
        wr(MHF_REG_CTRL, 32'h2);
        for (int k = 0; k < 2000 && mem_u.mem[32][15] !== 1'b1; k++)
            @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
        chk("bad_op_status", 32'h40018000, mem_u.mem[32]);
        chk("na_masked", 0, n_na);
        chk_tbl();
        rd(MHF_REG_STAT, d);
        chk("state_again", MHF_SUSP, d[3:0]);
        wrap_up();
    end
endmodule : mhf_setup_tb_top
